// File: hw/fbl_pkg.sv
// Constants, encodings and the pattern decode for the fieldbus status LED driver.
// Assumes a single 20 MHz core clock and a synchronous active-low reset.
// Contract
// - The steady blink pattern is lit for 200 ms and dark for 200 ms, with no longer pause.
// - A pattern of n blinks gives n lit pulses of 200 ms with 200 ms gaps, then one second dark.
// - Positions 4, 5, 6 show remote check, bus active and outgoing disabled; 1, 2, 3 show run, power, error.
// - The green bus-active LED is lit while the module transmits and dark otherwise.
// - The remote-check LED is lit only when the incoming link is good and no bus reset is asserted.
// - The yellow outgoing-disabled LED is lit whenever the outgoing segment is disabled.
// - The next-node sense input detects a downstream node, and with none the ring is closed locally.
// - The power LED is lit while logic power is adequate and dark otherwise.
// - During self test both the run and the error LED show the two-blink pattern.
// - When operational with a matching configuration, run is on and error is off.
// - A fatal error stops the island, turns run off and blinks error steadily, for good.
package fbl_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int BLINK_MS = 200;
  localparam int GAP_MS = 1000;
  localparam logic [9:0] BLINK_TICKS = 10'(BLINK_MS * 1000 / TICK_US);
  localparam logic [9:0] GAP_TICKS = 10'(GAP_MS * 1000 / TICK_US);

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_STATE_LSB = 0;
  localparam int CTRL_OUTDIS_BIT = 4;
  localparam int STATUS_LED_LSB = 0;
  localparam int STATUS_SENSE_BIT = 8;
  localparam int STATUS_FATAL_BIT = 9;
  localparam logic [3:0] STATE_RESET = 4'h0;
  localparam logic OUTDIS_RESET = 1'b0;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAT_OFF = 2'b00,
    PAT_ON = 2'b01,
    PAT_STEADY = 2'b10,
    PAT_COUNT = 2'b11
  } fbl_pat_t;

  typedef enum logic [3:0] {
    ST_SELFTEST = 4'h0,
    ST_INIT = 4'h1,
    ST_PREOP = 4'h2,
    ST_AUTOCFG = 4'h3,
    ST_CFG_DONE = 4'h4,
    ST_NO_MODULES = 4'h5,
    ST_ASSIGN_ERR = 4'h6,
    ST_PROTO_ERR = 4'h7,
    ST_FATAL = 4'h8,
    ST_OPERATIONAL = 4'h9,
    ST_MISMATCH = 4'hA,
    ST_STOPPED = 4'hB,
    ST_INTERNAL_FAIL = 4'hC
  } fbl_island_t;

  // Returns {pattern, blink count} for the run LED, or for the error LED when isErr is set.
  function automatic logic [4:0] decodeLed(input logic [3:0] state, input logic isErr);
    logic [4:0] run;
    logic [4:0] err;
    run = {PAT_OFF, 3'h0};
    err = {PAT_OFF, 3'h0};
    case (state)
      ST_SELFTEST:
      begin
        run = {PAT_COUNT, 3'h2};
        err = {PAT_COUNT, 3'h2};
      end
      ST_PREOP: run = {PAT_COUNT, 3'h1};
      ST_AUTOCFG: run = {PAT_STEADY, 3'h0};
      ST_CFG_DONE: run = {PAT_COUNT, 3'h3};
      ST_NO_MODULES: err = {PAT_COUNT, 3'h6};
      ST_ASSIGN_ERR: err = {PAT_COUNT, 3'h2};
      ST_PROTO_ERR: err = {PAT_COUNT, 3'h5};
      ST_FATAL: err = {PAT_STEADY, 3'h0};
      ST_OPERATIONAL: run = {PAT_ON, 3'h0};
      ST_MISMATCH:
      begin
        run = {PAT_ON, 3'h0};
        err = {PAT_COUNT, 3'h3};
      end
      ST_STOPPED: run = {PAT_COUNT, 3'h4};
      ST_INTERNAL_FAIL: err = {PAT_ON, 3'h0};
      default:
      begin
        run = {PAT_OFF, 3'h0};
        err = {PAT_OFF, 3'h0};
      end
    endcase
    return isErr ? err : run;
  endfunction

endpackage

// File: hw/fbl_pattern_gen.sv
// One LED pattern sequencer: off, on, steady blink or a counted blink train.
// Assumes a one-cycle tick every millisecond and a restart pulse on each state change.
`timescale 1ns/100ps
module fbl_pattern_gen (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic restart,
  input wire logic [1:0] mode,
  input wire logic [2:0] count,
  output logic led
);

  typedef struct packed {
    logic lit;
    logic [9:0] timer;
    logic [2:0] pulses;
    logic led;
  } fbl_gen_state_t;

  fbl_gen_state_t s_reg;
  fbl_gen_state_t s_next;
  logic lastDone;

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    lastDone = (mode == fbl_pkg::PAT_COUNT) && (s_reg.pulses >= count);
    if (restart)
    begin
      s_next.lit = 1'b1;
      s_next.timer = 10'h000;
      s_next.pulses = 3'h0;
    end
    else if (tick)
    begin
      s_next.timer = s_reg.timer + 10'h001;
      if (s_reg.lit && s_reg.timer == fbl_pkg::BLINK_TICKS - 10'h001)
      begin
        s_next.lit = 1'b0;
        s_next.timer = 10'h000;
        s_next.pulses = s_reg.pulses + 3'h1;
      end
      else if (!s_reg.lit && !lastDone && s_reg.timer == fbl_pkg::BLINK_TICKS - 10'h001)
      begin
        s_next.lit = 1'b1;
        s_next.timer = 10'h000;
      end
      else if (!s_reg.lit && lastDone && s_reg.timer == fbl_pkg::GAP_TICKS - 10'h001)
      begin
        s_next.lit = 1'b1;
        s_next.timer = 10'h000;
        s_next.pulses = 3'h0;
      end
    end
    // The gap after the last pulse replaces the ordinary dark gap, so it is a full second.
    unique case (mode)
      fbl_pkg::PAT_OFF: s_next.led = 1'b0;
      fbl_pkg::PAT_ON: s_next.led = 1'b1;
      fbl_pkg::PAT_STEADY: s_next.led = s_next.lit;
      fbl_pkg::PAT_COUNT: s_next.led = s_next.lit;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign led = s_reg.led;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_PULSE_END: assert property (s_reg.lit && tick && !restart
      && s_reg.timer == fbl_pkg::BLINK_TICKS - 10'h001 |=> !s_reg.lit && s_reg.timer == 10'h000)
    else $error("Lit pulse did not end after its length.");
  AST_LONG_GAP: assert property (mode == fbl_pkg::PAT_COUNT && !s_reg.lit && s_reg.pulses >= count
      && s_reg.timer < fbl_pkg::GAP_TICKS - 10'h001 && !restart |=> !s_reg.lit)
    else $error("Gap after a blink train ended early.");
  AST_RESTART: assert property (restart |=> s_reg.lit && s_reg.timer == 10'h000
      && s_reg.pulses == 3'h0)
    else $error("Restart did not begin at the first lit pulse.");

endmodule

// File: hw/fbl_led_driver.sv
// Top of the fieldbus status LED driver with its AHB-Lite register slave.
// Assumes status inputs on core_clk except the next-node sense pin, and one bus master.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module fbl_led_driver #(
  parameter int TICK_CYCLES = fbl_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic txActive,
  input wire logic inLinkOk,
  input wire logic busResetReq,
  input wire logic powerGood,
  input wire logic next_node_sense,
  output logic ringCloseLocal,
  output logic islandStop,
  output logic ledRun,
  output logic ledPower,
  output logic ledErr,
  output logic remote_check_indicator,
  output logic ledBusActive,
  output logic ledOutDisabled
);

  typedef struct packed {
    logic dphValid;
    logic dphWrite;
    logic [7:0] dphAddr;
    logic [31:0] rdata;
    logic [3:0] islandState;
    logic outDisable;
    logic fatal;
    logic [2:0] senseSync;
    logic sensed;
    logic [15:0] tickCnt;
    logic tick;
    logic [3:0] shownState;
    logic restart;
    logic [5:0] leds;
    logic ringClose;
  } fbl_top_state_t;

  fbl_top_state_t s_reg;
  fbl_top_state_t s_next;
  logic runLed;
  logic errLed;
  logic [4:0] runPat;
  logic [4:0] errPat;
  logic [3:0] effState;

  // ---------------------------------------------------------------------------
  // Register slave, timebase and status logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.restart = 1'b0;
    // Data phase of a write: the bus never stalls, so this is one cycle.
    if (s_reg.dphValid && s_reg.dphWrite && s_reg.dphAddr == fbl_pkg::CTRL_OFFSET)
    begin
      if (!s_reg.fatal)
        s_next.islandState = hwdata[fbl_pkg::CTRL_STATE_LSB +: 4];
      s_next.outDisable = hwdata[fbl_pkg::CTRL_OUTDIS_BIT];
    end
    // A fatal state latches until reset; later writes cannot restart the island.
    if (s_next.islandState == fbl_pkg::ST_FATAL)
      s_next.fatal = 1'b1;
    s_next.dphValid = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready)
    begin
      s_next.dphWrite = hwrite;
      s_next.dphAddr = {haddr[7:2], 2'b00};
    end
    s_next.rdata = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      if ({haddr[7:2], 2'b00} == fbl_pkg::CTRL_OFFSET)
      begin
        s_next.rdata[fbl_pkg::CTRL_STATE_LSB +: 4] = s_next.islandState;
        s_next.rdata[fbl_pkg::CTRL_OUTDIS_BIT] = s_next.outDisable;
      end
      else if ({haddr[7:2], 2'b00} == fbl_pkg::STATUS_OFFSET)
      begin
        s_next.rdata[fbl_pkg::STATUS_LED_LSB +: 6] = s_reg.leds;
        s_next.rdata[fbl_pkg::STATUS_SENSE_BIT] = s_reg.sensed;
        s_next.rdata[fbl_pkg::STATUS_FATAL_BIT] = s_reg.fatal;
      end
    end
    // Three stages on the pin; a level counts once the last two agree.
    s_next.senseSync = {s_reg.senseSync[1:0], next_node_sense};
    if (s_reg.senseSync[1] == s_reg.senseSync[2])
      s_next.sensed = s_reg.senseSync[2];
    s_next.ringClose = !s_reg.sensed;
    s_next.tick = 1'b0;
    if (s_reg.tickCnt == 16'(TICK_CYCLES - 1))
    begin
      s_next.tickCnt = 16'h0000;
      s_next.tick = 1'b1;
    end
    else
      s_next.tickCnt = s_reg.tickCnt + 16'h0001;
    if (effState != s_reg.shownState)
    begin
      s_next.shownState = effState;
      s_next.restart = 1'b1;
      // Realigning the timebase keeps the first pulse after a change a full length.
      s_next.tickCnt = 16'h0000;
      s_next.tick = 1'b0;
    end
    s_next.leds[0] = runLed;
    s_next.leds[1] = powerGood;
    s_next.leds[2] = errLed;
    s_next.leds[3] = inLinkOk && !busResetReq;
    s_next.leds[4] = txActive;
    s_next.leds[5] = s_reg.outDisable || s_reg.ringClose;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.islandState <= fbl_pkg::STATE_RESET;
      s_reg.outDisable <= fbl_pkg::OUTDIS_RESET;
      s_reg.ringClose <= 1'b1;
      s_reg.leds <= 6'h20;
    end
    else
      s_reg <= s_next;
  end

  // The shown state trails the register by one cycle, which costs nothing visible.
  assign effState = s_reg.fatal ? fbl_pkg::ST_FATAL : s_reg.islandState;
  assign runPat = fbl_pkg::decodeLed(s_reg.shownState, 1'b0);
  assign errPat = fbl_pkg::decodeLed(s_reg.shownState, 1'b1);

  // ---------------------------------------------------------------------------
  // Pattern sequencers
  // ---------------------------------------------------------------------------
  fbl_pattern_gen runGen (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(s_reg.tick),
    .restart(s_reg.restart),
    .mode(runPat[4:3]),
    .count(runPat[2:0]),
    .led(runLed)
  );

  fbl_pattern_gen errGen (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(s_reg.tick),
    .restart(s_reg.restart),
    .mode(errPat[4:3]),
    .count(errPat[2:0]),
    .led(errLed)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign ringCloseLocal = s_reg.ringClose;
  assign islandStop = s_reg.fatal;
  assign ledRun = s_reg.leds[0];
  assign ledPower = s_reg.leds[1];
  assign ledErr = s_reg.leds[2];
  assign remote_check_indicator = s_reg.leds[3];
  assign ledBusActive = s_reg.leds[4];
  assign ledOutDisabled = s_reg.leds[5];

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence fatalSeen;
    islandStop ##1 islandStop;
  endsequence

  AST_BUS_ACTIVE: assert property (txActive |=> ledBusActive)
    else $error("Bus active LED dark while transmitting.");
  AST_REMOTE_CHECK: assert property (##1 remote_check_indicator
      == $past(inLinkOk && !busResetReq))
    else $error("Remote check LED does not follow link and reset.");
  AST_OUT_DISABLED: assert property (ringCloseLocal |=> ledOutDisabled)
    else $error("Closed ring not shown as outgoing disabled.");
  AST_SENSE_FILTER: assert property ($changed(s_reg.sensed)
      |-> $past(s_reg.senseSync[1] == s_reg.senseSync[2]))
    else $error("Sense changed without agreeing stages.");
  AST_RING_CLOSE: assert property (!s_reg.sensed [*2] |=> ringCloseLocal)
    else $error("Ring not closed with no downstream node.");
  AST_POWER: assert property (##1 ledPower == $past(powerGood))
    else $error("Power LED does not follow logic power.");
  AST_SELFTEST: assert property (s_reg.shownState == fbl_pkg::ST_SELFTEST
      |-> runPat == {fbl_pkg::PAT_COUNT, 3'h2} && errPat == {fbl_pkg::PAT_COUNT, 3'h2})
    else $error("Self test does not blink twice on both LEDs.");
  AST_OPERATIONAL: assert property (s_reg.islandState == fbl_pkg::ST_OPERATIONAL
      && !s_reg.fatal [*3] |=> ledRun && !ledErr)
    else $error("Operational state not shown as run on, error off.");
  AST_FATAL: assert property (fatalSeen ##1 islandStop |=> islandStop && !ledRun)
    else $error("Fatal error did not stop the island with run off.");

endmodule

// File: tb/fbl_led_observer.sv
// Stand-in for the operator watching one LED: measures each lit or dark phase.
// Assumes the LED output is a register on core_clk, high meaning lit.
`timescale 1ns/100ps
module fbl_led_observer (
  input wire logic core_clk,
  input wire logic led,
  output logic lastLevel,
  output logic [31:0] lastLen,
  output logic [31:0] phases
);
  // ---------------------------------------------------------------------------
  // Phase measurement
  // ---------------------------------------------------------------------------
  // A phase is closed when the LED changes, so its length counts whole cycles.
  logic prevLed = 1'b0;
  logic [31:0] runLen = 32'h0;
  initial
  begin
    lastLevel = 1'b0;
    lastLen = 32'h0;
    phases = 32'h0;
  end
  always @(posedge core_clk)
  begin
    prevLed <= led;
    if (led !== prevLed)
    begin
      lastLevel <= prevLed;
      lastLen <= runLen;
      phases <= phases + 32'h1;
      runLen <= 32'h1;
    end
    else
    begin
      runLen <= runLen + 32'h1;
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the fieldbus status LED driver, driven over AHB-Lite.
// Assumes a 20 MHz core_clk and a shortened tick of four cycles.
`timescale 1ns/100ps
module tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  // A short tick keeps the one second gap to a few thousand cycles.
  localparam int TK = 4;
  localparam int PUL = int'(fbl_pkg::BLINK_TICKS) * TK;
  localparam int GAPC = int'(fbl_pkg::GAP_TICKS) * TK;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, txActive = 1'b0, inLinkOk = 1'b0;
  logic busResetReq = 1'b0, powerGood = 1'b0, next_node_sense = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ringCloseLocal, islandStop, ledRun, ledPower, ledErr;
  logic remote_check_indicator, ledBusActive, ledOutDisabled, lvR, lvE;
  logic [31:0] lenR, lenE, phR, phE;
  int err_total = 0;
  int total_checks = 0;
  int i;
  logic [3:0] codes [3] = '{4'h9, 4'hC, 4'h1};
  logic runExp [3] = '{1'b1, 1'b0, 1'b0};
  logic errExp [3] = '{1'b0, 1'b1, 1'b0};

  fbl_led_driver #(.TICK_CYCLES(TK)) fbl_led_driver_inst (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .txActive(txActive), .inLinkOk(inLinkOk), .busResetReq(busResetReq),
    .powerGood(powerGood), .next_node_sense(next_node_sense),
    .ringCloseLocal(ringCloseLocal), .islandStop(islandStop), .ledRun(ledRun),
    .ledPower(ledPower), .ledErr(ledErr), .remote_check_indicator(remote_check_indicator),
    .ledBusActive(ledBusActive), .ledOutDisabled(ledOutDisabled));
  fbl_led_observer runObs (.core_clk(core_clk), .led(ledRun), .lastLevel(lvR),
    .lastLen(lenR), .phases(phR));
  fbl_led_observer errObs (.core_clk(core_clk), .led(ledErr), .lastLevel(lvE),
    .lastLen(lenE), .phases(phE));

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic stall();
    err_total++;
    report_and_stop();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
      if (n > 20)
        stall();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rdata = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Waits for the next closed phase of one LED; a zero length is not compared.
  task automatic phase(input bit e, input logic lvl, input int len);
    int n;
    logic [31:0] p;
    p = e ? phE : phR;
    n = 0;
    while ((e ? phE : phR) === p)
    begin
      @(posedge core_clk);
      n++;
      if (n > 6000)
        stall();
    end
    chk(32'(e ? lvE : lvR), 32'(lvl));
    if (len > 0)
      chk(e ? lenE : lenR, 32'(len));
  endtask

  task automatic train(input bit e, input int n, input bit steady);
    int k;
    phase(e, 1'b0, 0);
    for (k = 0; k < n; k++)
    begin
      phase(e, 1'b1, PUL);
      phase(e, 1'b0, (steady || k < n - 1) ? PUL : GAPC);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk({ledRun, ledPower, ledErr, ledBusActive, ledOutDisabled}, 32'h1);
    chk({ringCloseLocal, islandStop}, 32'h2);
    wr(32'h0, 32'h1);
    for (i = 0; i < 16; i++)
    begin
      {txActive, inLinkOk, busResetReq, powerGood} <= 4'(i);
      repeat (3) @(posedge core_clk);
      chk(32'(ledBusActive), 32'(i[3]));
      chk(32'(remote_check_indicator), 32'(i[2] & ~i[1]));
      chk(32'(ledPower), 32'(i[0]));
      rd(32'h4);
      chk(32'(rdata[5:0]), {26'h0, 1'b1, i[3], i[2] & ~i[1], 1'b0, i[0], 1'b0});
    end
    for (i = 0; i < 3; i++)
    begin
      wr(32'h0, 32'(codes[i]));
      repeat (8) @(posedge core_clk);
      chk({ledRun, ledErr}, {30'h0, runExp[i], errExp[i]});
    end
    next_node_sense <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk({ringCloseLocal, ledOutDisabled}, 32'h0);
    wr(32'h0, 32'h11);
    repeat (3) @(posedge core_clk);
    chk(32'(ledOutDisabled), 32'h1);
    wr(32'h0, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(32'(ledOutDisabled), 32'h0);
    next_node_sense <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk({ringCloseLocal, ledOutDisabled}, 32'h3);
    wr(32'h0, 32'h0);
    fork
      train(1'b0, 2, 1'b0);
      train(1'b1, 2, 1'b0);
    join
    phase(1'b0, 1'b1, PUL);
    repeat (100) @(posedge core_clk);
    wr(32'h0, 32'h2);
    phase(1'b0, 1'b0, 0);
    chk(32'(lenR < 300), 32'h1);
    phase(1'b0, 1'b1, PUL);
    phase(1'b0, 1'b0, GAPC);
    wr(32'h0, 32'hA);
    train(1'b1, 3, 1'b0);
    chk(32'(ledRun), 32'h1);
    wr(32'h0, 32'h1);
    repeat (10) @(posedge core_clk);
    wr(32'h0, 32'h3);
    train(1'b0, 3, 1'b1);
    wr(32'h0, 32'h8);
    train(1'b1, 2, 1'b1);
    chk({ledRun, islandStop}, 32'h1);
    wr(32'h0, 32'h9);
    repeat (10) @(posedge core_clk);
    chk({ledRun, islandStop}, 32'h1);
    rd(32'h0);
    chk(32'(rdata[3:0]), 32'h8);
    rd(32'h4);
    chk(32'(rdata[9]), 32'h1);
    rd(32'h10);
    chk(rdata, 32'h0);
    chk(32'(hresp), 32'h0);
    report_and_stop();
  end
endmodule
